/* File: psbs_ext_master.sv */
// model of the external parallel master that writes and reads byte slots
`timescale 1ns/10ps
module psbs_ext_master
	import psbs_pkg::*;
(
	input  wire logic    aclk,
	output psbs_ext_wr_t ext_wr,
	output psbs_ext_rd_t ext_rd
);
	// extra idle cycles after each byte, so the master can be prompt or slow
	int gap = 0;

	// idle bus at time zero
	initial begin
		ext_wr = '0;
		ext_rd = '0;
	end

	// one write pulse, released after its edge so no stale byte lingers
	task automatic put(input logic [1:0] s, input logic [7:0] d);
		ext_wr <= '{valid: 1'b1, slot: s, data: d};
		@(posedge aclk);
		ext_wr <= '0;
		repeat (gap + 1) @(posedge aclk);
	endtask : put

	// one read pulse; the byte comes back one cycle later
	task automatic get(input logic [1:0] s);
		ext_rd <= '{valid: 1'b1, slot: s};
		@(posedge aclk);
		ext_rd <= '0;
		repeat (gap + 1) @(posedge aclk);
	endtask : get
endmodule : psbs_ext_master

/* File: psbs_map.svh */
// register offsets, field positions and reset values of the slave buffer status block
`ifndef PSBS_MAP_SVH
`define PSBS_MAP_SVH

// byte offsets on the register bus and the slot decode mask
`define PSBS_OFF_STAT      8'h00
`define PSBS_OFF_CLR       8'h04
`define PSBS_OFF_SET       8'h08
`define PSBS_OFF_INV       8'h0c
`define PSBS_OFF_IN0       8'h10
`define PSBS_OFF_OUT0      8'h20
`define PSBS_OFF_EVST      8'h30
`define PSBS_OFF_EVMSK     8'h34
`define PSBS_OFF_CTRL      8'h38
`define PSBS_SLOT_MASK     8'hf3

// status word fields
`define PSBS_B_IN_ALL      15
`define PSBS_B_IN_OVF      14
`define PSBS_B_IN_SLOT     8
`define PSBS_B_OUT_ALL     7
`define PSBS_B_OUT_UNF     6
`define PSBS_B_OUT_SLOT    0
`define PSBS_STAT_RSVD     32'hffff_3030

// event status bits
`define PSBS_EV_IN_RX      0
`define PSBS_EV_OVF        1
`define PSBS_EV_UNF        2
`define PSBS_EV_OUT_TX     3

// reset values
`define PSBS_RST_OUT_EMPTY 4'hf
`define PSBS_RST_MODE      1'b1

// bus responses
`define PSBS_RESP_OKAY     2'b00
`define PSBS_RESP_SLVERR   2'b10

`endif

/* File: psbs_pkg.sv */
// types of the slave buffer status block
package psbs_pkg;

	// write of one byte by the external master
	typedef struct packed {
		logic       valid;
		logic [1:0] slot;
		logic [7:0] data;
	} psbs_ext_wr_t;

	// read of one byte by the external master
	typedef struct packed {
		logic       valid;
		logic [1:0] slot;
	} psbs_ext_rd_t;

	// whole state of the block
	typedef struct packed {
		logic [3:0][7:0] in_data;
		logic [3:0]      in_full;
		logic [3:0][7:0] out_data;
		logic [3:0]      out_empty;
		logic            ovf;
		logic            unf;
		logic            mode;
		logic [3:0]      ev_st;
		logic [3:0]      ev_mask;
		logic            aw_v;
		logic [7:0]      aw_addr;
		logic            w_v;
		logic [31:0]     w_data;
		logic [3:0]      w_strb;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
		logic [7:0]      ext_rd_data;
		logic            ext_rd_ok;
	} psbs_state_t;

endpackage : psbs_pkg

/* File: psbs_top.sv */
// slave buffer status block: four input and four output byte buffers with axi4-lite registers
`timescale 1ns/10ps
`include "psbs_map.svh"

module psbs_top
	import psbs_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   awaddr,
	input  wire logic         awvalid,
	output logic              awready,
	input  wire logic [31:0]  wdata,
	input  wire logic [3:0]   wstrb,
	input  wire logic         wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  wire logic         bready,
	input  wire logic [7:0]   araddr,
	input  wire logic         arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  wire logic         rready,
	input  wire psbs_ext_wr_t ext_wr,
	input  wire psbs_ext_rd_t ext_rd,
	output logic [7:0]        ext_rd_data,
	output logic              ext_rd_ok,
	output logic              all_inputs_full,
	output logic              all_outputs_empty,
	output logic              irq
);

	// ************************************************************
	// state and decode signals
	// ************************************************************
	psbs_state_t q;             // registered state
	psbs_state_t d;             // next state
	logic [31:0] stat;          // status word as software sees it
	logic [31:0] wmask;         // byte strobes widened to bits
	logic [31:0] alias_val;     // status after a base or alias write
	logic        wr_go;         // address and data both held
	logic        ar_go;         // read address taken this cycle
	logic        w_in;          // write address hits an input slot
	logic        w_out;         // write address hits an output slot
	logic        r_in;          // read address hits an input slot
	logic        r_out;         // read address hits an output slot
	logic        w_stat;        // write hits status or an alias
	logic        ovf_ev;        // external write into a full slot
	logic        unf_ev;        // external read from an empty slot
	logic        rx_ev;         // external write stored
	logic        tx_ev;         // external read served
	logic        ev_clr;        // event status read this cycle

	// ************************************************************
	// handshake outputs
	// ************************************************************
	// one write and one read at a time: channels stall while an answer waits
	assign awready = !q.aw_v && !q.bvalid;
	assign wready  = !q.w_v && !q.bvalid;
	assign arready = !q.rvalid;
	assign wr_go   = q.aw_v && q.w_v;
	assign ar_go   = arvalid && arready;

	// registered outputs, and the aggregate flags and irq decoded from registered state
	assign bvalid      = q.bvalid;
	assign bresp       = q.bresp;
	assign rvalid      = q.rvalid;
	assign rdata       = q.rdata;
	assign rresp       = q.rresp;
	assign ext_rd_data = q.ext_rd_data;
	assign ext_rd_ok   = q.ext_rd_ok;
	assign all_inputs_full   = stat[`PSBS_B_IN_ALL];
	assign all_outputs_empty = stat[`PSBS_B_OUT_ALL];
	assign irq               = |(q.ev_st & q.ev_mask);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		d      = q;
		ovf_ev = 1'b0;
		unf_ev = 1'b0;
		rx_ev  = 1'b0;
		tx_ev  = 1'b0;
		ev_clr = 1'b0;
		// status word, unused positions tied low
		stat = 32'h0000_0000;
		stat[`PSBS_B_IN_ALL]  = &q.in_full;
		stat[`PSBS_B_IN_OVF]  = q.ovf;
		stat[`PSBS_B_IN_SLOT +: 4]  = q.in_full;
		stat[`PSBS_B_OUT_ALL] = &q.out_empty;
		stat[`PSBS_B_OUT_UNF] = q.unf;
		stat[`PSBS_B_OUT_SLOT +: 4] = q.out_empty;
		wmask  = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
		w_in   = (q.aw_addr & `PSBS_SLOT_MASK) == `PSBS_OFF_IN0;
		w_out  = (q.aw_addr & `PSBS_SLOT_MASK) == `PSBS_OFF_OUT0;
		r_in   = (araddr & `PSBS_SLOT_MASK) == `PSBS_OFF_IN0;
		r_out  = (araddr & `PSBS_SLOT_MASK) == `PSBS_OFF_OUT0;
		w_stat = q.aw_addr[7:4] == 4'h0;
		// base write stores, aliases clear, set or toggle the written ones
		unique case (q.aw_addr[3:2])
			2'h0:    alias_val = (stat & ~wmask) | (q.w_data & wmask);
			2'h1:    alias_val = stat & ~(q.w_data & wmask);
			2'h2:    alias_val = stat | (q.w_data & wmask);
			default: alias_val = stat ^ (q.w_data & wmask);
		endcase
		// served pulse lasts one cycle unless another byte goes out
		d.ext_rd_ok = 1'b0;

		// external read first, so a same-cycle software fill wins
		if (q.mode && ext_rd.valid) begin
			if (q.out_empty[ext_rd.slot]) begin
				unf_ev = 1'b1;
			end else begin
				d.ext_rd_data = q.out_data[ext_rd.slot];
				d.ext_rd_ok   = 1'b1;
				d.out_empty[ext_rd.slot] = 1'b1;
				tx_ev = 1'b1;
			end
		end

		// write channel capture
		if (awvalid && awready) begin
			d.aw_v    = 1'b1;
			d.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			d.w_v    = 1'b1;
			d.w_data = wdata;
			d.w_strb = wstrb;
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end

		// write execution once both halves are held
		if (wr_go) begin
			d.aw_v   = 1'b0;
			d.w_v    = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = `PSBS_RESP_OKAY;
			if (w_stat) begin
				// only the two error flags are writable
				d.ovf = alias_val[`PSBS_B_IN_OVF];
				d.unf = alias_val[`PSBS_B_OUT_UNF];
			end else if (w_out) begin
				if (q.w_strb[0]) begin
					d.out_data[q.aw_addr[3:2]]  = q.w_data[7:0];
					d.out_empty[q.aw_addr[3:2]] = 1'b0;
				end
			end else if (w_in || q.aw_addr == `PSBS_OFF_EVST) begin
				// read-only words: write accepted and dropped
			end else if (q.aw_addr == `PSBS_OFF_EVMSK) begin
				if (q.w_strb[0]) begin
					d.ev_mask = q.w_data[3:0];
				end
			end else if (q.aw_addr == `PSBS_OFF_CTRL) begin
				if (q.w_strb[0]) begin
					d.mode = q.w_data[0];
				end
			end else begin
				d.bresp = `PSBS_RESP_SLVERR;
			end
		end

		// read channel
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end
		if (ar_go) begin
			d.rvalid = 1'b1;
			d.rresp  = `PSBS_RESP_OKAY;
			d.rdata  = 32'h0000_0000;
			if (araddr == `PSBS_OFF_STAT) begin
				d.rdata = stat;
			end else if (araddr[7:4] == 4'h0) begin
				// aliases are write-only and read as zero
			end else if (r_in) begin
				d.rdata[7:0] = q.in_data[araddr[3:2]];
				d.in_full[araddr[3:2]] = 1'b0;
			end else if (r_out) begin
				d.rdata[7:0] = q.out_data[araddr[3:2]];
			end else if (araddr == `PSBS_OFF_EVST) begin
				d.rdata[3:0] = q.ev_st;
				ev_clr = 1'b1;
			end else if (araddr == `PSBS_OFF_EVMSK) begin
				d.rdata[3:0] = q.ev_mask;
			end else if (araddr == `PSBS_OFF_CTRL) begin
				d.rdata[0] = q.mode;
			end else begin
				d.rresp = `PSBS_RESP_SLVERR;
			end
		end

		// external write last, so a fresh byte beats a same-cycle read clear
		if (q.mode && ext_wr.valid) begin
			if (q.in_full[ext_wr.slot]) begin
				ovf_ev = 1'b1;
				// held byte and full flag untouched
			end else begin
				d.in_data[ext_wr.slot] = ext_wr.data;
				d.in_full[ext_wr.slot] = 1'b1;
				rx_ev = 1'b1;
			end
		end

		// hardware set wins over a software clear in the same cycle
		d.ovf = d.ovf | ovf_ev;
		d.unf = d.unf | unf_ev;
		d.ev_st = (ev_clr ? 4'h0 : q.ev_st) | {tx_ev, unf_ev, ovf_ev, rx_ev};
	end

	// ************************************************************
	// state register
	// ************************************************************
	// one register for the whole state keeps all next-state logic in one place;
	// the reset branch loads constants only, so buffers come up drained
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q           <= '0;
			q.out_empty <= `PSBS_RST_OUT_EMPTY;
			q.mode      <= `PSBS_RST_MODE;
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// status read taken, answer next cycle
	sequence s_stat_rd;
		ar_go && araddr == `PSBS_OFF_STAT;
	endsequence

	// external write into a full slot in slave mode
	sequence s_ovf_wr;
		q.mode && ext_wr.valid && q.in_full[ext_wr.slot];
	endsequence

	property p_in_all;
		s_stat_rd |=> rdata[`PSBS_B_IN_ALL] == &$past(q.in_full);
	endproperty
	a_in_all: assert property (p_in_all) else $error("aggregate input full wrong");

	property p_ovf_set;
		s_ovf_wr |=> q.ovf ##1 (q.ovf || $past(wr_go));
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");

	property p_in_clr;
		ar_go && r_in && !(q.mode && ext_wr.valid && ext_wr.slot == araddr[3:2])
			|=> !q.in_full[$past(araddr[3:2])];
	endproperty
	a_in_clr: assert property (p_in_clr) else $error("input slot not cleared by read");

	property p_out_all;
		s_stat_rd |=> rdata[`PSBS_B_OUT_ALL] == &$past(q.out_empty);
	endproperty
	a_out_all: assert property (p_out_all) else $error("aggregate output empty wrong");

	property p_unf_set;
		q.mode && ext_rd.valid && q.out_empty[ext_rd.slot] |=> q.unf && !ext_rd_ok;
	endproperty
	a_unf_set: assert property (p_unf_set) else $error("underflow not set");

	property p_out_fill;
		wr_go && w_out && q.w_strb[0] |=> !q.out_empty[$past(q.aw_addr[3:2])];
	endproperty
	a_out_fill: assert property (p_out_fill) else $error("output slot still empty");

	property p_rsvd;
		s_stat_rd |=> (rdata & `PSBS_STAT_RSVD) == 32'h0000_0000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("unused status bits not zero");

	property p_alias_clr;
		wr_go && q.aw_addr == `PSBS_OFF_CLR && q.w_strb[1] && q.w_data[`PSBS_B_IN_OVF] && !ovf_ev |=> !q.ovf;
	endproperty
	a_alias_clr: assert property (p_alias_clr) else $error("clear alias did not clear");

	property p_mode_off;
		!q.mode && !ar_go |=> $stable(q.in_full) && (!$rose(q.unf) || $past(wr_go));
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("flags moved outside slave mode");

	property p_err_cause;
		$rose(q.ovf) |-> $past(ovf_ev || (wr_go && w_stat));
	endproperty
	a_err_cause: assert property (p_err_cause) else $error("overflow set without cause");

	property p_unf_cause;
		$rose(q.unf) |-> $past(unf_ev || (wr_go && w_stat));
	endproperty
	a_unf_cause: assert property (p_unf_cause) else $error("underflow set without cause");

	// error flags are sticky: only a register write may drop them
	property p_ovf_hold;
		q.ovf && !wr_go |=> q.ovf;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow dropped by itself");

	property p_unf_hold;
		q.unf && !wr_go |=> q.unf;
	endproperty
	a_unf_hold: assert property (p_unf_hold) else $error("underflow dropped by itself");

	// byte from the far side lands in an empty slot and marks it full
	sequence s_in_wr;
		q.mode && ext_wr.valid && !q.in_full[ext_wr.slot];
	endsequence

	property p_in_store;
		s_in_wr |=> q.in_full[$past(ext_wr.slot)] && q.in_data[$past(ext_wr.slot)] == $past(ext_wr.data);
	endproperty
	a_in_store: assert property (p_in_store) else $error("received byte not stored");

	// a served read returns the stored byte with a one-cycle pulse
	property p_serve;
		q.mode && ext_rd.valid && !q.out_empty[ext_rd.slot]
			|=> ext_rd_ok && ext_rd_data == $past(q.out_data[ext_rd.slot]);
	endproperty
	a_serve: assert property (p_serve) else $error("served byte wrong");

	// held byte survives an overflowing write
	for (genvar i = 0; i < 4; i++) begin : g_keep
		property p_keep;
			s_ovf_wr and ext_wr.slot == i
				|=> (q.in_full[i] || $past(ar_go && r_in && araddr[3:2] == i)) && q.in_data[i] == $past(q.in_data[i]);
		endproperty
		a_keep: assert property (p_keep) else $error("overflow changed held byte");
	end

endmodule : psbs_top

/* File: psbs_top_test.sv */
// self-checking bench of the slave buffer status block
`timescale 1ns/10ps
module psbs_top_test
	import psbs_pkg::*;
;
	// ****************
	// signals
	// ****************
	logic         aclk = 0, aresetn = 0;
	logic [7:0]   awaddr = '0, araddr = '0;
	logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0]  wdata = '0;
	logic [3:0]   wstrb = '0;
	logic         awready, wready, bvalid, arready, rvalid, ext_rd_ok;
	logic         all_inputs_full, all_outputs_empty, irq;
	logic [1:0]   bresp, rresp;
	logic [31:0]  rdata;
	logic [7:0]   ext_rd_data;
	psbs_ext_wr_t ext_wr;
	psbs_ext_rd_t ext_rd;
	int           n_errors = 0, cmp_count = 0;
	logic [33:0]  rq[$];       // expected {rresp, rdata}
	logic [7:0]   eq[$], b[4]; // expected served bytes, slot data

	// 100 ns clock
	always #50 aclk = ~aclk;

	psbs_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ext_wr(ext_wr), .ext_rd(ext_rd), .ext_rd_data(ext_rd_data), .ext_rd_ok(ext_rd_ok),
		.all_inputs_full(all_inputs_full), .all_outputs_empty(all_outputs_empty), .irq(irq));
	psbs_ext_master em (.aclk(aclk), .ext_wr(ext_wr), .ext_rd(ext_rd));

	// ****************
	// tasks
	// ****************
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h, want %h", $time, s, e);
		end
	endtask : chk

	// write: both halves offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit pa = 0, pw = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge aclk);
			pa |= awvalid & awready;
			pw |= wvalid & wready;
			awvalid <= !pa;
			wvalid <= !pw;
		end while (!(pa && pw));
		bready <= 1;
		do @(posedge aclk); while (!bvalid);
		bready <= 0;
		chk(bresp, r);
	endtask : wr

	// read: expectation noted first, the monitor compares it
	task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
		bit pa = 0;
		rq.push_back({r, d});
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			pa |= arvalid & arready;
			arvalid <= !pa;
		end while (!(pa && rvalid));
		rready <= 0;
		// one quiet edge, so a following read never flips rready within one step
		@(posedge aclk);
	endtask : rd

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask : tdone

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	// ****************
	// monitor
	// ****************
	// an unexpected served byte finds the queue empty, is compared with a value it cannot match and is flagged as a mismatch
	always @(posedge aclk) begin
		if (rvalid && rready)
			chk({rresp, rdata}, rq.pop_front());
		if (ext_rd_ok)
			chk(ext_rd_data, eq.size() ? eq.pop_front() : 34'h3_0000_0000);
	end

	// hang guard, far beyond the roughly 150 cycles the tests need
	initial begin
		repeat (4000) @(posedge aclk);
		n_errors++;
		$display("unexpected at %0t: watchdog", $time);
		end_of_test;
	end

	// ****************
	// tests
	// ****************
	initial begin
		void'($urandom(28847));
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk({all_inputs_full, all_outputs_empty, irq}, 3'b010);
		rd(8'h00, 0, 32'h0000_008f);
		rd(8'h38, 0, 1);
		tdone("reset");
		foreach (b[i]) begin
			chk(all_inputs_full, 0);
			b[i] = $urandom;
			em.put(2'(i), b[i]);
		end
		chk(all_inputs_full, 1);
		rd(8'h00, 0, 32'h8f8f);
		em.put(2, ~b[2]);
		rd(8'h00, 0, 32'hcf8f);
		rd(8'h18, 0, b[2]);
		chk(all_inputs_full, 0);
		rd(8'h00, 0, 32'h4b8f);
		tdone("input fill and overflow");
		wr(8'h04, 32'h4000, 0);
		rd(8'h00, 0, 32'h0b8f);
		wr(8'h08, '1, 0);
		rd(8'h00, 0, 32'h4bcf);
		wr(8'h0c, 32'h4040, 0);
		rd(8'h00, 0, 32'h0b8f);
		rd(8'h04, 0, 0);
		tdone("aliases");
		// skip the slot already drained
		foreach (b[i]) if (i != 2) rd(8'h10 + 8'(4 * i), 0, b[i]);
		rd(8'h00, 0, 32'h0000_008f);
		foreach (b[i]) begin
			b[i] = $urandom;
			wr(8'h20 + 8'(4 * i), b[i], 0);
			chk(all_outputs_empty, 0);
		end
		rd(8'h00, 0, 0);
		em.gap = 3;
		foreach (b[i]) begin
			eq.push_back(b[i]);
			em.get(2'(i));
		end
		em.gap = 0;
		chk(all_outputs_empty, 1);
		rd(8'h00, 0, 32'h0000_008f);
		tdone("output fill and drain");
		rd(8'h30, 0, 32'hb);
		rd(8'h30, 0, 0);
		wr(8'h34, 32'h4, 0);
		em.put(0, $urandom);
		chk(irq, 0);
		em.get(1);
		chk(irq, 1);
		rd(8'h00, 0, 32'h01cf);
		rd(8'h30, 0, 32'h5);
		chk(irq, 0);
		wr(8'h04, 32'h40, 0);
		tdone("underflow and interrupt");
		rd(8'h3c, 2'b10, 0);
		wr(8'h3c, '1, 2'b10);
		wr(8'h38, 0, 0);
		em.put(1, 8'h5a);
		em.get(2);
		rd(8'h00, 0, 32'h018f);
		wr(8'h38, 1, 0);
		tdone("unmapped and master mode");
		end_of_test;
	end
endmodule : psbs_top_test
